// ### src/oam_exec.sv
/*
 * Executor for the literal OR, register OR and register copy
 * instructions, each run over four quarter phases of one instruction cycle.
 * Assumes the fetch logic holds instr_i steady from the decode quarter to
 * the write quarter and raises instr_valid_i in the decode quarter.
 * Assumes software expects the file registers to be unknown until written.
 */
`timescale 1ns/100ps
`include "oam_defs.svh"

// Function
// - The literal-OR opcode ORs the low byte into the accumulator.
// - The register-OR opcode ORs the addressed file register with the accumulator.
// - With the target bit clear the register-OR result goes to the accumulator only.
// - With the target bit set the register-OR result goes back to the file register only.
// - The copy opcode moves the addressed file register unaltered to the chosen target.
// - Copy with target clear writes the accumulator, with target set rewrites the source.
// - Copy updates the zero flag, so copying a register onto itself tests it for zero.
// - Each instruction takes one word and one cycle of decode, read, process and write.
module oam_exec
  import oam_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 7
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Instruction.
  input wire logic [13:0] instr_i,
  input wire logic instr_valid_i,
  // State.
  output logic [DATA_W-1:0] accumulator_o,
  output logic null_result_flag_o,
  output logic [1:0] phase_o,
  output logic done_o,
  output logic illegal_o
);
  initial begin
    if (DATA_W != 8) begin
      $error("oam_exec: only an 8-bit data path is served.");
    end
    if (ADDR_W != 7) begin
      $error("oam_exec: only a 7-bit register index is served.");
    end
    if (`OAM_QUARTERS != 4) begin
      $error("oam_exec: the sequencer serves four quarters only.");
    end
  end

  // Registered state and the next values that feed it.
  oam_phase_t phase;
  oam_phase_t next_phase;
  oam_op_t op;
  oam_op_t next_op;
  logic busy;
  logic next_busy;
  logic [DATA_W-1:0] accumulator_reg;
  logic [DATA_W-1:0] next_accumulator_reg;
  logic null_result_flag;
  logic next_null_result_flag;
  logic [DATA_W-1:0] result;
  logic [DATA_W-1:0] next_result;
  logic done;
  logic next_done;
  logic illegal;
  logic next_illegal;
  logic file_wr_en;
  logic [DATA_W-1:0] file_rd_data;

  logic [5:0] opcode;
  logic result_target_bit;
  logic [ADDR_W-1:0] operand_register_index;
  logic [DATA_W-1:0] immediate_byte;

  // Operand fields are cut straight from the held instruction word.
  assign opcode = instr_i[`OAM_OPC_MSB:`OAM_OPC_LSB];
  assign result_target_bit = instr_i[`OAM_TARGET_BIT];
  assign operand_register_index = instr_i[`OAM_INDEX_MSB:0];
  assign immediate_byte = instr_i[`OAM_IMM_MSB:0];

  // The index is presented for the whole cycle, so the registered read
  // data are settled by the process quarter. The memory has no reset, which
  // saves a clear sequence but leaves every register unknown until written.
  oam_file_regs #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W)
  ) u_file_regs (
    .clk_i(clk_i),
    .rd_addr_i(operand_register_index),
    .rd_data_o(file_rd_data),
    .wr_en_i(file_wr_en),
    .wr_addr_i(operand_register_index),
    .wr_data_i(result)
  );

  // Sequencer: the quarter counter rests in decode until an instruction is
  // offered, so an idle core spends no write quarter on a stale word.
  always_comb begin
    next_phase = phase;
    next_busy = busy;
    next_done = 1'b0;
    case (phase)
      OAM_Q_DECODE: begin
        if (instr_valid_i) begin
          next_busy = 1'b1;
          next_phase = OAM_Q_READ;
        end
      end
      OAM_Q_READ: begin
        next_phase = OAM_Q_PROCESS;
      end
      OAM_Q_PROCESS: begin
        next_phase = OAM_Q_WRITE;
      end
      OAM_Q_WRITE: begin
        next_phase = OAM_Q_DECODE;
        next_busy = 1'b0;
        next_done = busy;
      end
      default: begin
        next_phase = OAM_Q_DECODE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase <= OAM_Q_DECODE;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      phase <= next_phase;
      busy <= next_busy;
      done <= next_done;
    end
  end

  // Decoder: the operation is latched in the decode quarter; an unknown
  // opcode is flagged and still runs its four quarters without writing.
  always_comb begin
    next_op = op;
    next_illegal = illegal;
    if (phase == OAM_Q_DECODE && instr_valid_i) begin
      next_illegal = 1'b0;
      case (opcode)
        `OAM_OPC_LIT_OR: next_op = OAM_OP_LIT_OR;
        `OAM_OPC_REG_OR: next_op = OAM_OP_REG_OR;
        `OAM_OPC_COPY: next_op = OAM_OP_COPY;
        default: begin
          next_op = OAM_OP_NONE;
          next_illegal = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      op <= OAM_OP_NONE;
      illegal <= 1'b0;
    end else begin
      op <= next_op;
      illegal <= next_illegal;
    end
  end

  // Data path: the result is formed in the process quarter and committed in
  // the write quarter, so the file write and the flag see one settled value.
  always_comb begin
    next_accumulator_reg = accumulator_reg;
    next_null_result_flag = null_result_flag;
    next_result = result;
    file_wr_en = 1'b0;
    case (phase)
      OAM_Q_PROCESS: begin
        case (op)
          OAM_OP_LIT_OR: next_result = accumulator_reg | immediate_byte;
          OAM_OP_REG_OR: next_result = accumulator_reg | file_rd_data;
          OAM_OP_COPY: next_result = file_rd_data;
          default: next_result = result;
        endcase
      end
      OAM_Q_WRITE: begin
        if (busy && op != OAM_OP_NONE) begin
          next_null_result_flag = (result == '0);
          // A file target leaves the accumulator as it was.
          if (op == OAM_OP_LIT_OR || !result_target_bit) begin
            next_accumulator_reg = result;
          end else begin
            file_wr_en = 1'b1;
          end
        end
      end
      default: begin
        next_result = result;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      accumulator_reg <= `OAM_ACC_RESET;
      null_result_flag <= `OAM_FLAG_RESET;
      result <= '0;
    end else begin
      accumulator_reg <= next_accumulator_reg;
      null_result_flag <= next_null_result_flag;
      result <= next_result;
    end
  end

  // The outputs are the registers themselves, so no combinational path
  // reaches a port.
  assign accumulator_o = accumulator_reg;
  assign null_result_flag_o = null_result_flag;
  assign phase_o = phase;
  assign done_o = done;
  assign illegal_o = illegal;
endmodule

// ### src/oam_defs.svh
/*
 * Constants for the OR and move instruction executor: opcode fields,
 * operand positions, reset values and quarter-phase counts.
 * Assumes a 14-bit instruction word and an 8-bit data path.
 */
`ifndef OAM_DEFS_SVH
`define OAM_DEFS_SVH

`define OAM_OPC_LIT_OR 6'h38
`define OAM_OPC_REG_OR 6'h04
`define OAM_OPC_COPY 6'h08
`define OAM_OPC_MSB 13
`define OAM_OPC_LSB 8
`define OAM_TARGET_BIT 7
`define OAM_INDEX_MSB 6
`define OAM_IMM_MSB 7
`define OAM_ACC_RESET 8'h00
`define OAM_FLAG_RESET 1'b0
`define OAM_QUARTERS 4

`endif

// ### src/oam_pkg.sv
/*
 * Types shared by the OR and move instruction executor.
 * Assumes oam_defs.svh supplies the numeric constants.
 */
package oam_pkg;
  typedef enum logic [1:0] {
    OAM_Q_DECODE,
    OAM_Q_READ,
    OAM_Q_PROCESS,
    OAM_Q_WRITE
  } oam_phase_t;

  typedef enum logic [1:0] {
    OAM_OP_NONE,
    OAM_OP_LIT_OR,
    OAM_OP_REG_OR,
    OAM_OP_COPY
  } oam_op_t;
endpackage

// ### src/oam_file_regs.sv
/*
 * Small file-register memory for the executor: 128 bytes with one
 * registered read port and one write port.
 * Assumes a single clock; the read data appear the cycle after the address.
 */
`timescale 1ns/100ps
module oam_file_regs #(
  parameter int ADDR_W = 7,
  parameter int DATA_W = 8
) (
  // Clock.
  input wire logic clk_i,
  // Read port.
  input wire logic [ADDR_W-1:0] rd_addr_i,
  output logic [DATA_W-1:0] rd_data_o,
  // Write port.
  input wire logic wr_en_i,
  input wire logic [ADDR_W-1:0] wr_addr_i,
  input wire logic [DATA_W-1:0] wr_data_i
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  initial begin
    if (ADDR_W < 1 || DATA_W < 1) begin
      $error("oam_file_regs: widths must be positive.");
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end
endmodule

// ### tb/oam_exec_properties.sv
/* Port checker for the OR and move executor.
   Assumes it is bound to every oam_exec instance. */
`timescale 1ns/100ps
module oam_exec_checker #(
  parameter int DATA_W = 8
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Instruction.
  input wire logic [13:0] instr_i,
  input wire logic instr_valid_i,
  // State.
  input wire logic [DATA_W-1:0] accumulator_o,
  input wire logic null_result_flag_o,
  input wire logic [1:0] phase_o,
  input wire logic done_o,
  input wire logic illegal_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic take;
  logic bad;
  assign take = instr_valid_i && phase_o == 2'h0;
  assign bad = !(instr_i[13:8] inside {6'h38, 6'h04, 6'h08});
  a_phase_step: assert property ((phase_o != 2'h0 || instr_valid_i) |=>
    phase_o == $past(phase_o) + 2'h1)
    else $error("quarter did not advance");
  a_idle_hold: assert property (phase_o == 2'h0 && !instr_valid_i |=> phase_o == 2'h0)
    else $error("quarter left decode without an instruction");
  a_start_done: assert property (take |-> ##4 done_o)
    else $error("done missing four cycles after start");
  a_done_once: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  a_done_cause: assert property (done_o |-> $past(take, 4))
    else $error("done without a start");
  a_acc_steady: assert property (!done_o |-> $stable(accumulator_o))
    else $error("accumulator moved outside write");
  a_lit_or: assert property (take && instr_i[13:8] == 6'h38 |-> ##4
    accumulator_o == ($past(accumulator_o, 4) | $past(instr_i[7:0], 4)))
    else $error("literal OR result wrong");
  a_acc_kept: assert property (take && (bad || instr_i[13:7] inside {7'h09, 7'h11}) |-> ##4
    accumulator_o == $past(accumulator_o, 4))
    else $error("accumulator changed by file target");
  a_bad_opcode: assert property (take && bad |-> ##4
    illegal_o && null_result_flag_o == $past(null_result_flag_o, 4))
    else $error("unknown opcode handled wrongly");
  a_zero_flag: assert property (done_o && ($past(instr_i[13:8], 4) == 6'h38 ||
    $past(instr_i[13:7], 4) inside {7'h08, 7'h10}) |->
    null_result_flag_o == (accumulator_o == 8'h00))
    else $error("zero flag does not match result");
endmodule
bind oam_exec oam_exec_checker #(.DATA_W(DATA_W)) u_oam_exec_checker (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .instr_i(instr_i), .instr_valid_i(instr_valid_i),
  .accumulator_o(accumulator_o), .null_result_flag_o(null_result_flag_o),
  .phase_o(phase_o), .done_o(done_o), .illegal_o(illegal_o));

// ### tb/oam_exec_bench.sv
/* Self-checking bench for the OR and move executor.
   Assumes file registers start unknown, so register 5, the only one used, is first filled by OR with 8'hff. */
`timescale 1ns/100ps
module oam_exec_bench;
  typedef struct {logic rst; logic [13:0] ins; logic [7:0] acc; logic z; logic bad;} oam_row_t;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [13:0] instr_i = 14'h0000;
  logic instr_valid_i = 1'b0;
  logic [7:0] accumulator_o;
  logic null_result_flag_o;
  logic [1:0] phase_o;
  logic done_o;
  logic illegal_o;
  int err_total = 0;
  int cmp_count = 0;
  oam_row_t rows [15] = '{'{0, 14'h3800, 8'h00, 1, 0}, '{0, 14'h3835, 8'h35, 0, 0},
    '{0, 14'h389a, 8'hbf, 0, 0}, '{0, 14'h38ff, 8'hff, 0, 0}, '{0, 14'h0485, 8'hff, 0, 0},
    '{1, 14'h0805, 8'hff, 0, 0}, '{1, 14'h3801, 8'h01, 0, 0}, '{0, 14'h0485, 8'h01, 0, 0},
    '{0, 14'h0885, 8'h01, 0, 0}, '{1, 14'h3800, 8'h00, 1, 0}, '{0, 14'h0885, 8'h00, 0, 0},
    '{0, 14'h0405, 8'hff, 0, 0}, '{1, 14'h3800, 8'h00, 1, 0}, '{0, 14'h1285, 8'h00, 1, 1},
    '{0, 14'h3810, 8'h10, 0, 0}};
  oam_exec u_oam_exec (.clk_i(clk_i), .rst_n_i(rst_n_i), .instr_i(instr_i),
    .instr_valid_i(instr_valid_i), .accumulator_o(accumulator_o),
    .null_result_flag_o(null_result_flag_o), .phase_o(phase_o), .done_o(done_o),
    .illegal_o(illegal_o));
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    chk_byte({7'h00, g}, {7'h00, e});
  endtask
  task automatic do_reset(input int n);
    rst_n_i = 1'b0;
    repeat (n) @(posedge clk_i);
    #2;
    chk_byte(accumulator_o, 8'h00);
    chk_byte({3'h0, null_result_flag_o, phase_o, done_o, illegal_o}, 8'h00);
    rst_n_i = 1'b1;
  endtask
  // Starts at the next decode quarter and checks the write four edges later.
  task automatic run(input logic [13:0] ins, input logic [7:0] a, input logic z, input logic b);
    int n;
    n = 0;
    while (phase_o !== 2'h0 && n < 8) begin
      @(posedge clk_i);
      #2;
      n++;
    end
    if (phase_o !== 2'h0) begin
      err_total++;
      print_verdict();
    end
    instr_i = ins;
    instr_valid_i = 1'b1;
    @(posedge clk_i);
    #2;
    instr_valid_i = 1'b0;
    repeat (3) begin
      chk_bit(done_o, 1'b0);
      @(posedge clk_i);
      #2;
    end
    chk_bit(done_o, 1'b1);
    chk_byte(accumulator_o, a);
    chk_bit(null_result_flag_o, z);
    chk_bit(illegal_o, b);
  endtask
  initial begin
    do_reset(6);
    foreach (rows[i]) begin
      if (rows[i].rst) do_reset(2);
      run(rows[i].ins, rows[i].acc, rows[i].z, rows[i].bad);
    end
    // A reset in mid-instruction must abandon the pending literal OR.
    instr_i = 14'h3855;
    instr_valid_i = 1'b1;
    @(posedge clk_i);
    #2;
    instr_valid_i = 1'b0;
    @(posedge clk_i);
    #2;
    do_reset(2);
    run(14'h3800, 8'h00, 1'b1, 1'b0);
    print_verdict();
  end
endmodule
